/* File: pkg/btc_map.svh */
// register-free constants for the block-transfer channel
`ifndef BTC_MAP_SVH
`define BTC_MAP_SVH
`define BTC_W 24
`define BTC_AW 18
`define BTC_BLOCK_BIT 23
`define BTC_DIR_BIT 22
`define BTC_OVR_BIT 21
`define BTC_CHAIN_BIT 22
`define BTC_RESTART_BIT 23
`define BTC_SKIP_LSB 12
`define BTC_SKIP_W 12
`define BTC_WC_W 12
`define BTC_ST_IRQ_BIT 2
`define BTC_IRQ_NS 475
`define BTC_CLK_NS 20
`define BTC_PARAM_WORDS 2
`endif

/* File: pkg/btc_pkg.sv */
// types shared by the block-transfer channel
`include "btc_map.svh"
package btc_pkg;
	typedef enum logic [2:0] {
		BTC_NOP,
		BTC_CMD_OUT,
		BTC_DATA_OUT,
		BTC_DATA_IN,
		BTC_STATUS_IN,
		BTC_ADDR_OUT,
		BTC_ADDR_IN,
		BTC_PARAM_IN
	} btc_op_t;
	typedef struct packed {
		logic valid;
		btc_op_t op;
		logic [`BTC_W-1:0] acc;
	} btc_instr_t;
	typedef struct packed {
		logic req;
		logic write;
		logic [`BTC_AW-1:0] addr;
		logic [`BTC_W-1:0] wdata;
	} btc_mem_req_t;
endpackage : btc_pkg

/* File: design/btc_channel.sv */
// block-transfer io channel: instruction decode, block engine, unit handshake
`timescale 1ns/10ps
`default_nettype none
module btc_channel
	import btc_pkg::*;
#(
	parameter int IRQ_NS = `BTC_IRQ_NS,
	parameter int CLK_NS = `BTC_CLK_NS
) (
	// clock and reset
	input wire logic clk_i,
	input wire logic rst_n_i,
	// cpu instruction port
	input wire btc_instr_t instr_i,
	output logic accepted_o,
	output logic not_zero_o,
	output logic [`BTC_W-1:0] acc_o,
	// memory port
	output btc_mem_req_t mem_o,
	input wire logic mem_grant_i,
	input wire logic [`BTC_W-1:0] mem_rdata_i,
	// unit pins
	input wire logic data_avail_i,
	input wire logic unit_accepted_i,
	input wire logic connected_i,
	input wire logic disc_conn_i,
	input wire logic buffer_empty_irq_enable_i,
	input wire logic status_bit2_i,
	input wire logic irq_en_i,
	input wire logic [`BTC_W-1:0] unit_data_i,
	input wire logic [`BTC_W-1:0] unit_status_i,
	output logic [`BTC_W-1:0] unit_data_o,
	output logic data_here_o,
	output logic cmd_here_o,
	output logic accept_o,
	// interrupts and busy flag
	output logic out_irq_o,
	output logic wc_irq_o,
	output logic busy_o
);
	localparam int IRQ_CYC = (IRQ_NS / CLK_NS) < 1 ? 1 : IRQ_NS / CLK_NS;
	initial begin
		if (IRQ_NS <= 0 || CLK_NS <= 0 || IRQ_CYC > 255)
			$error("btc_channel: bad irq timing parameters");
	end

	typedef enum logic [3:0] {
		S_IDLE, S_PAR, S_OUT_RD, S_OUT_HS, S_IN_WAIT, S_IN_HS, S_IN_WR,
		S_DONE
	} btc_state_t;

	// ---------------------------------------------------------------
	// reset and pin synchronisers
	// ---------------------------------------------------------------
	logic rst_q1, rst_q2;
	logic [6:0] pin_q1, pin_q2;
	logic [2*`BTC_W-1:0] word_q1, word_q2;
	logic data_avail, unit_acc, connected, disc_conn, ecbe, st2, irq_en;

	// reset release through two flops
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			rst_q1 <= 1'b0;
			rst_q2 <= 1'b0;
		end else begin
			rst_q1 <= 1'b1;
			rst_q2 <= rst_q1;
		end
	end

	// unit pins pass two flops
	always_ff @(posedge clk_i or negedge rst_q2) begin
		if (!rst_q2) begin
			pin_q1 <= '0;
			pin_q2 <= '0;
			word_q1 <= '0;
			word_q2 <= '0;
		end else begin
			pin_q1 <= {data_avail_i, unit_accepted_i, connected_i, disc_conn_i,
				buffer_empty_irq_enable_i, status_bit2_i, irq_en_i};
			pin_q2 <= pin_q1;
			word_q1 <= {unit_data_i, unit_status_i};
			word_q2 <= word_q1;
		end
	end
	assign {data_avail, unit_acc, connected, disc_conn, ecbe, st2, irq_en} =
		pin_q2;

	// ---------------------------------------------------------------
	// channel state
	// ---------------------------------------------------------------
	btc_state_t state;
	logic [`BTC_AW-1:0] transfer_address_reg, parameter_address_reg, par_ptr;
	logic [`BTC_WC_W-1:0] word_count_reg;
	logic [`BTC_SKIP_W-1:0] skip_counter;
	logic [`BTC_W-1:0] second_parameter_word, in_buf;
	logic [1:0] par_idx;
	logic dir_in, chain, single_busy, hs_pending, hs_cmd, in_armed, ack_armed;
	logic [7:0] irq_cnt;
	logic block_busy, blk_cmd, ovr, take_out, take_in, take_st, refused;

	assign block_busy = (state != S_IDLE);
	assign ovr = instr_i.acc[`BTC_OVR_BIT];
	assign blk_cmd = instr_i.acc[`BTC_BLOCK_BIT];

	// instruction acceptance decode
	always_comb begin
		take_out = 1'b0;
		take_in = 1'b0;
		take_st = 1'b0;
		refused = 1'b0;
		if (instr_i.valid) begin
			case (instr_i.op)
				BTC_CMD_OUT:
					take_out = !single_busy && (!block_busy || ovr);
				BTC_DATA_OUT:
					take_out = !single_busy && !block_busy;
				BTC_DATA_IN:
					take_in = !single_busy && !block_busy && !disc_conn &&
						data_avail && in_armed;
				BTC_STATUS_IN:
					take_st = !single_busy && connected;
				default: ;
			endcase
			case (instr_i.op)
				BTC_CMD_OUT, BTC_DATA_OUT: refused = !take_out;
				BTC_DATA_IN: refused = !take_in;
				BTC_STATUS_IN: refused = !take_st;
				BTC_NOP: refused = 1'b1;
				default: refused = 1'b0;
			endcase
		end
	end
	assign accepted_o = instr_i.valid && !refused;
	assign not_zero_o = instr_i.valid && refused;
	assign busy_o = block_busy || single_busy;

	// single-word output handshake to the unit
	always_ff @(posedge clk_i or negedge rst_q2) begin
		if (!rst_q2) begin
			single_busy <= 1'b0;
			hs_pending <= 1'b0;
			hs_cmd <= 1'b0;
			unit_data_o <= '0;
		end else if (take_out && !(instr_i.op == BTC_CMD_OUT && blk_cmd)) begin
			single_busy <= 1'b1;
			hs_pending <= 1'b1;
			hs_cmd <= (instr_i.op == BTC_CMD_OUT);
			unit_data_o <= instr_i.acc;
		end else if (state == S_PAR && mem_grant_i && par_idx == 2'd2) begin
			unit_data_o <= mem_rdata_i; // chained command to the unit
			hs_pending <= 1'b1;
			hs_cmd <= 1'b1;
		end else if (state == S_OUT_RD && mem_grant_i) begin
			unit_data_o <= mem_rdata_i;
			hs_pending <= 1'b1;
			hs_cmd <= 1'b0;
		end else if (hs_pending && unit_acc && ack_armed && connected &&
			!disc_conn) begin
			hs_pending <= 1'b0;
			single_busy <= 1'b0;
		end
	end

	// synced unit lines must fall before they count again
	always_ff @(posedge clk_i or negedge rst_q2) begin
		if (!rst_q2) begin
			in_armed <= 1'b1;
			ack_armed <= 1'b1;
		end else begin
			if (accept_o)
				in_armed <= 1'b0;
			else if (!data_avail)
				in_armed <= 1'b1;
			if (hs_pending && unit_acc && ack_armed && connected && !disc_conn)
				ack_armed <= 1'b0;
			else if (!unit_acc)
				ack_armed <= 1'b1;
		end
	end
	assign data_here_o = hs_pending && !hs_cmd && connected && !disc_conn;
	assign cmd_here_o = hs_pending && hs_cmd && connected && !disc_conn;

	// cpu read-back word
	always_ff @(posedge clk_i or negedge rst_q2) begin
		if (!rst_q2) begin
			acc_o <= '0;
		end else if (instr_i.valid) begin
			case (instr_i.op)
				BTC_DATA_IN: acc_o <= word_q2[2*`BTC_W-1:`BTC_W];
				BTC_STATUS_IN: acc_o <= word_q2[`BTC_W-1:0];
				BTC_ADDR_IN: acc_o <= {{(`BTC_W-`BTC_AW){1'b0}},
					transfer_address_reg};
				BTC_PARAM_IN: acc_o <= {{(`BTC_W-`BTC_AW){1'b0}},
					parameter_address_reg};
				default: acc_o <= acc_o;
			endcase
		end
	end
	assign accept_o = (take_in || state == S_IN_HS) && !disc_conn;

	// parameter address register
	always_ff @(posedge clk_i or negedge rst_q2) begin
		if (!rst_q2)
			parameter_address_reg <= '0;
		else if (instr_i.valid && instr_i.op == BTC_ADDR_OUT)
			parameter_address_reg <= instr_i.acc[`BTC_AW-1:0];
	end

	// ---------------------------------------------------------------
	// block transfer engine
	// ---------------------------------------------------------------
	always_ff @(posedge clk_i or negedge rst_q2) begin
		if (!rst_q2) begin
			state <= S_IDLE;
			par_idx <= '0;
			par_ptr <= '0;
			dir_in <= 1'b0;
			chain <= 1'b0;
			transfer_address_reg <= '0;
			word_count_reg <= '0;
			skip_counter <= '0;
			second_parameter_word <= '0;
			in_buf <= '0;
		end else begin
			case (state)
				S_IDLE: if (take_out && instr_i.op == BTC_CMD_OUT && blk_cmd) begin
					dir_in <= instr_i.acc[`BTC_DIR_BIT];
					par_ptr <= parameter_address_reg;
					par_idx <= '0;
					state <= S_PAR;
				end
				S_PAR: if (mem_grant_i) begin
					par_ptr <= par_ptr + 1'b1;
					par_idx <= par_idx + 1'b1;
					if (par_idx == 2'd0) begin
						word_count_reg <= mem_rdata_i[`BTC_WC_W-1:0];
						skip_counter <= mem_rdata_i[`BTC_SKIP_LSB +:
							`BTC_SKIP_W];
					end else if (par_idx == 2'd1) begin
						transfer_address_reg <= mem_rdata_i[`BTC_AW-1:0];
						second_parameter_word <= mem_rdata_i;
						chain <= mem_rdata_i[`BTC_CHAIN_BIT];
						if (!mem_rdata_i[`BTC_CHAIN_BIT])
							state <= dir_in ? S_IN_WAIT : S_OUT_RD;
					end else begin
						dir_in <= mem_rdata_i[`BTC_DIR_BIT];
						state <= mem_rdata_i[`BTC_DIR_BIT] ? S_IN_WAIT :
							S_OUT_RD;
					end
				end
				S_OUT_RD: if (word_count_reg == '0) begin
					state <= S_DONE;
				end else if (!hs_pending && mem_grant_i) begin
					transfer_address_reg <= transfer_address_reg + 1'b1;
					word_count_reg <= word_count_reg - 1'b1;
					state <= S_OUT_HS;
				end
				S_OUT_HS: if (!hs_pending)
					state <= S_OUT_RD;
				S_IN_WAIT: if (word_count_reg == '0) begin
					state <= S_DONE;
				end else if (data_avail && in_armed && !disc_conn) begin
					in_buf <= word_q2[2*`BTC_W-1:`BTC_W];
					state <= S_IN_HS;
				end
				S_IN_HS: if (!disc_conn) begin
					if (skip_counter != '0) begin
						skip_counter <= skip_counter - 1'b1;
						state <= S_IN_WAIT;
					end else begin
						state <= S_IN_WR;
					end
				end
				S_IN_WR: if (mem_grant_i) begin
					transfer_address_reg <= transfer_address_reg + 1'b1;
					word_count_reg <= word_count_reg - 1'b1;
					state <= S_IN_WAIT;
				end
				S_DONE: if (second_parameter_word[`BTC_RESTART_BIT]) begin
					par_ptr <= par_ptr;
					par_idx <= '0;
					state <= S_PAR;
				end else begin
					state <= S_IDLE;
				end
				default: state <= S_IDLE;
			endcase
		end
	end

	// memory request, held until grant, single outstanding
	always_comb begin
		mem_o = '0;
		case (state)
			S_PAR: begin
				mem_o.req = 1'b1;
				mem_o.addr = par_ptr;
			end
			S_OUT_RD: begin
				mem_o.req = (word_count_reg != '0) && !hs_pending;
				mem_o.addr = transfer_address_reg;
			end
			S_IN_WR: begin
				mem_o.req = 1'b1;
				mem_o.write = 1'b1;
				mem_o.addr = transfer_address_reg;
				mem_o.wdata = in_buf;
			end
			default: mem_o = '0;
		endcase
	end

	// ---------------------------------------------------------------
	// interrupts
	// ---------------------------------------------------------------
	// word-count-complete pulse after the final word
	always_ff @(posedge clk_i or negedge rst_q2) begin
		if (!rst_q2) begin
			irq_cnt <= '0;
			wc_irq_o <= 1'b0;
		end else if ((state == S_OUT_RD || state == S_IN_WAIT) &&
			word_count_reg == '0) begin
			irq_cnt <= 8'(IRQ_CYC - 1);
			wc_irq_o <= 1'b1;
		end else if (irq_cnt != '0) begin
			irq_cnt <= irq_cnt - 1'b1;
		end else begin
			wc_irq_o <= 1'b0;
		end
	end

	// output interrupt
	always_ff @(posedge clk_i or negedge rst_q2) begin
		if (!rst_q2)
			out_irq_o <= 1'b0;
		else if (!ecbe)
			out_irq_o <= irq_en && st2;
		else
			out_irq_o <= irq_en && !disc_conn && !hs_pending;
	end
endmodule : btc_channel
`default_nettype wire

/* File: dv/btc_unit_model.sv */
// unit controller model on the far side of the channel
`timescale 1ns/10ps
`default_nettype none
module btc_unit_model (
	// clock
	input wire logic clk_i,
	// channel side
	input wire logic data_here_i,
	input wire logic cmd_here_i,
	input wire logic accept_i,
	input wire logic [23:0] word_i,
	// unit side
	output logic unit_accepted_o,
	output logic data_avail_o,
	output logic [23:0] data_o
);
	logic [23:0] rx_q[$];
	logic [23:0] nxt = 24'h000001;
	int stall = 0;
	int gap = 0;
	logic here, dh, ac;
	logic [23:0] w;
	// react just after each edge, with random stalls
	initial begin
		unit_accepted_o = 1'h0;
		data_avail_o = 1'h0;
		data_o = 24'h000000;
		forever begin
			@(posedge clk_i);
			// take the channel lines as the edge sees them
			here = data_here_i || cmd_here_i;
			dh = data_here_i;
			ac = accept_i;
			w = word_i;
			#1;
			if (here && !unit_accepted_o) begin
				if (stall == 0) begin
					unit_accepted_o = 1'h1;
					if (dh) rx_q.push_back(w);
					stall = $urandom_range(0, 4);
				end else stall--;
			end else if (unit_accepted_o && !here)
				unit_accepted_o = 1'h0;
			// released data lines show the inverse of the last word
			if (data_avail_o && ac) begin
				data_avail_o = 1'h0;
				data_o = ~data_o;
				nxt++;
				gap = $urandom_range(3, 6);
			end else if (!data_avail_o && gap == 0) begin
				data_avail_o = 1'h1;
				data_o = nxt;
			end else if (!data_avail_o) gap--;
		end
	end
endmodule : btc_unit_model
`default_nettype wire

/* File: dv/btc_channel_assertions.sv */
// port checker for the block-transfer channel
`timescale 1ns/10ps
`default_nettype none
`include "btc_map.svh"
module btc_channel_assertions
	import btc_pkg::*;
(
	// clock and reset
	input wire logic clk_i,
	input wire logic rst_n_i,
	// watched ports
	input wire btc_instr_t instr_i,
	input wire logic accepted_o,
	input wire logic not_zero_o,
	input wire logic [`BTC_W-1:0] acc_o,
	input wire btc_mem_req_t mem_o,
	input wire logic mem_grant_i,
	input wire logic disc_conn_i,
	input wire logic [`BTC_W-1:0] unit_data_o,
	input wire logic data_here_o,
	input wire logic wc_irq_o,
	input wire logic busy_o
);
	logic [`BTC_AW-1:0] par;
	logic par_ok;
	wire take = instr_i.valid && accepted_o;
	wire go = take && instr_i.op == BTC_CMD_OUT &&
		instr_i.acc[`BTC_BLOCK_BIT] && !busy_o;
	// last parameter address handed over
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			par <= '0;
			par_ok <= 1'h0;
		end else if (take && instr_i.op == BTC_ADDR_OUT) begin
			par <= instr_i.acc[`BTC_AW-1:0];
			par_ok <= 1'h1;
		end else if (go) begin
			par_ok <= 1'h0;
		end
	end
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!rst_n_i);
	property p_flag; instr_i.valid |-> accepted_o ^ not_zero_o; endproperty
	a_flag: assert property (p_flag) else $error("bad flag");
	property p_ref; instr_i.valid && busy_o && instr_i.op == BTC_DATA_OUT
		|-> not_zero_o; endproperty
	a_ref: assert property (p_ref) else $error("busy taken");
	property p_dout; take && instr_i.op == BTC_DATA_OUT
		|=> busy_o && unit_data_o == $past(instr_i.acc); endproperty
	a_dout: assert property (p_dout) else $error("bad out");
	property p_par; take && instr_i.op == BTC_PARAM_IN && par_ok
		|=> acc_o[`BTC_AW-1:0] == par; endproperty
	a_par: assert property (p_par) else $error("bad par");
	property p_fetch; go && par_ok
		|=> busy_o && mem_o.req && !mem_o.write && mem_o.addr == par; endproperty
	a_fetch: assert property (p_fetch) else $error("bad fetch");
	property p_hold; mem_o.req && !mem_grant_i
		|=> mem_o.req && $stable(mem_o.addr); endproperty
	a_hold: assert property (p_hold) else $error("req dropped");
	property p_irq; $rose(wc_irq_o)
		|-> wc_irq_o[*8] ##15 wc_irq_o ##1 !wc_irq_o; endproperty
	a_irq: assert property (p_irq) else $error("bad pulse");
	property p_disc; disc_conn_i[*3] |-> !data_here_o; endproperty
	a_disc: assert property (p_disc) else $error("early drop");
	c_go: cover property (go);
	c_irq: cover property ($rose(wc_irq_o));
	c_din: cover property (take && instr_i.op == BTC_DATA_IN);
endmodule : btc_channel_assertions
bind btc_channel btc_channel_assertions btc_channel_assertions_inst (.clk_i,
	.rst_n_i, .instr_i, .accepted_o, .not_zero_o, .acc_o, .mem_o, .mem_grant_i,
	.disc_conn_i, .unit_data_o, .data_here_o, .wc_irq_o, .busy_o);
`default_nettype wire

/* File: dv/block_transfer_io_channel_tb.sv */
// self-checking bench for the block-transfer channel
`timescale 1ns/10ps
`default_nettype none
`include "btc_map.svh"
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin error_cnt++; \
$display("mismatch at %0t: %0h vs %0h", $time, g, e); end end
module block_transfer_io_channel_tb import btc_pkg::*;;
	localparam logic [17:0] PA = 18'h00100;
	localparam logic [17:0] BUF = 18'h00200;
	localparam logic DIR_IN = 1'h1; // direction bit value for input
	logic clk_i = 1'h0;
	logic rst_n_i = 1'h0;
	logic mem_grant_i = 1'h0;
	logic connected_i = 1'h1;
	logic disc_conn_i = 1'h0;
	logic buffer_empty_irq_enable_i = 1'h1;
	logic status_bit2_i = 1'h0;
	logic irq_en_i = 1'h1;
	logic accepted_o, not_zero_o, data_here_o, cmd_here_o, accept_o, busy_o;
	logic out_irq_o, wc_irq_o, data_avail_i, unit_accepted_i, ok;
	logic [23:0] mem_rdata_i = 24'h000000;
	logic [23:0] unit_status_i = 24'h000000;
	logic [23:0] acc_o, unit_data_o, unit_data_i, s;
	btc_instr_t instr_i = '0;
	btc_mem_req_t mem_o;
	logic [23:0] mem [int];
	logic [23:0] exp_q[$];
	int error_cnt = 0;
	int n_compared = 0;
	int cyc = 0;
	int irq_n = 0;
	btc_channel btc_channel_inst (.clk_i, .rst_n_i, .instr_i, .accepted_o,
		.not_zero_o, .acc_o, .mem_o, .mem_grant_i, .mem_rdata_i, .data_avail_i,
		.unit_accepted_i, .connected_i, .disc_conn_i, .buffer_empty_irq_enable_i,
		.status_bit2_i, .irq_en_i, .unit_data_i, .unit_status_i, .unit_data_o,
		.data_here_o, .cmd_here_o, .accept_o, .out_irq_o, .wc_irq_o, .busy_o);
	btc_unit_model unit (.clk_i, .data_here_i(data_here_o),
		.cmd_here_i(cmd_here_o), .accept_i(accept_o), .word_i(unit_data_o),
		.unit_accepted_o(unit_accepted_i), .data_avail_o(data_avail_i),
		.data_o(unit_data_i));
	always #10 clk_i = ~clk_i;
	// hang guard and tally of cycles with the interrupt high
	always @(posedge clk_i) begin
		cyc++;
		irq_n += int'(wc_irq_o === 1'h1);
		if (cyc > 20000) begin
			error_cnt++;
			wrap_up();
		end
	end
	// memory: grant a held request after a random stall
	initial forever begin
		@(posedge clk_i);
		#1;
		if (mem_grant_i || mem_o.req !== 1'h1 || $urandom_range(0, 2) != 0) begin
			mem_grant_i = 1'h0;
			mem_rdata_i = ~mem_rdata_i;
		end else begin
			mem_grant_i = 1'h1;
			if (mem_o.write) mem[int'(mem_o.addr)] = mem_o.wdata;
			mem_rdata_i = mem[int'(mem_o.addr)];
		end
	end
	task automatic issue(input btc_op_t op, input logic [23:0] a, input int n);
		int k;
		k = 1;
		@(posedge clk_i);
		#1 instr_i = '{1'h1, op, a};
		#1 ok = accepted_o;
		while (ok !== 1'h1 && k < n) begin
			@(posedge clk_i);
			#2 ok = accepted_o;
			k++;
		end
		@(posedge clk_i);
		#1 instr_i.valid = 1'h0;
	endtask : issue
	task automatic settle();
		repeat (4) @(posedge clk_i);
		#1;
	endtask : settle
	task automatic wait_idle();
		int k;
		k = 0;
		do begin
			@(posedge clk_i);
			#3 k++;
		end while (busy_o !== 1'h0 && k < 3000);
		`CHK(busy_o, 1'h0)
		settle();
	endtask : wait_idle
	task automatic start_block(input logic dir, input int n, input int skip);
		mem[PA] = {skip[11:0], n[11:0]};
		mem[PA + 1] = {6'h00, BUF};
		issue(BTC_ADDR_OUT, {6'h00, PA}, 1);
		issue(BTC_PARAM_IN, 24'h000000, 1);
		`CHK(acc_o[17:0], PA)
		issue(BTC_CMD_OUT, {1'h1, dir, 22'h000000}, 1);
		`CHK(ok, 1'h1)
		issue(BTC_DATA_OUT, 24'h000000, 1);
		`CHK(ok, 1'h0)
	endtask : start_block
	task automatic wrap_up();
		$display("compared %0d, mismatches %0d", n_compared, error_cnt);
		if (error_cnt == 0 && n_compared > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask : wrap_up
	initial begin
		void'($urandom(62));
		repeat (12) @(posedge clk_i);
		#1 rst_n_i = 1'h1;
		settle();
		// single words, a busy refusal, then a held handshake
		repeat (4) begin
			exp_q.push_back($urandom);
			issue(BTC_DATA_OUT, exp_q[$], 100);
			issue(BTC_DATA_OUT, 24'h000000, 1);
			`CHK(ok, 1'h0)
			wait_idle();
		end
		disc_conn_i = 1'h1;
		exp_q.push_back(24'h5A5A5A);
		issue(BTC_DATA_OUT, 24'h5A5A5A, 100);
		settle();
		`CHK(unit.rx_q.size(), 4)
		issue(BTC_DATA_IN, 24'h000000, 1);
		`CHK(ok, 1'h0)
		disc_conn_i = 1'h0;
		wait_idle();
		foreach (exp_q[i]) `CHK(unit.rx_q[i], exp_q[i])
		s = unit.nxt;
		issue(BTC_DATA_IN, 24'h000000, 100);
		`CHK(acc_o, s)
		// status word needs a connected unit
		unit_status_i = $urandom;
		connected_i = 1'h0;
		settle();
		issue(BTC_STATUS_IN, 24'h000000, 1);
		`CHK(ok, 1'h0)
		connected_i = 1'h1;
		settle();
		issue(BTC_STATUS_IN, 24'h000000, 1);
		`CHK(acc_o, unit_status_i)
		// output interrupt follows status bit 2
		buffer_empty_irq_enable_i = 1'h0;
		status_bit2_i = 1'h1;
		settle();
		`CHK(out_irq_o, 1'h1)
		status_bit2_i = 1'h0;
		settle();
		`CHK(out_irq_o, 1'h0)
		// output block of four words
		for (int i = 0; i < 4; i++) mem[BUF + i] = $urandom;
		unit.rx_q.delete();
		start_block(~DIR_IN, 4, 0);
		wait_idle();
		for (int i = 0; i < 4; i++) `CHK(unit.rx_q[i], mem[BUF + i])
		issue(BTC_ADDR_IN, 24'h000000, 1);
		`CHK(acc_o[17:0], BUF + 18'h4)
		// input block skipping two words
		s = unit.nxt;
		start_block(DIR_IN, 3, 2);
		wait_idle();
		for (int i = 0; i < 3; i++) `CHK(mem[BUF + i], s + 24'(2 + i))
		issue(BTC_ADDR_IN, 24'h000000, 1);
		`CHK(acc_o[17:0], BUF + 18'h3)
		repeat (30) @(posedge clk_i);
		`CHK(irq_n, 46)
		wrap_up();
	end
endmodule : block_transfer_io_channel_tb
`default_nettype wire
